// >>> shared/eepi2c_defs.svh
`ifndef EEPI2C_DEFS_SVH
`define EEPI2C_DEFS_SVH

// ----------------------------------------
// array organisation
// ----------------------------------------
`define EEPI2C_PAGES        512
`define EEPI2C_PAGE_BYTES   256
`define EEPI2C_AW           17
`define EEPI2C_DW           8

// ----------------------------------------
// device address byte fields
// ----------------------------------------
`define EEPI2C_TYPE_HI      7
`define EEPI2C_TYPE_LO      4
`define EEPI2C_SEL_HI       3
`define EEPI2C_SEL_LO       2
`define EEPI2C_TOP_BIT      1
`define EEPI2C_RW_BIT       0

// ----------------------------------------
// word address byte fields
// ----------------------------------------
`define EEPI2C_WHI_MSB      15
`define EEPI2C_WHI_LSB      8
`define EEPI2C_WLO_MSB      7
`define EEPI2C_WLO_LSB      0
// arbitrary value, not a real device type code
`define EEPI2C_DEV_TYPE     4'h6

// ----------------------------------------
// bit counter values
// ----------------------------------------
`define EEPI2C_CNT_ZERO     4'h0
`define EEPI2C_CNT_ONE      4'h1
`define EEPI2C_CNT_ACK      4'h8

// ----------------------------------------
// programming cycle timing
// ----------------------------------------
`define EEPI2C_PROG_TIME_US 5000
`define EEPI2C_SYS_CLK_HZ   25000000
`define EEPI2C_PROG_CYCLES  (`EEPI2C_PROG_TIME_US * (`EEPI2C_SYS_CLK_HZ / 1000000))

`endif

// >>> shared/eepi2c_pkg.sv
`include "eepi2c_defs.svh"

package eepi2c_pkg;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef logic [`EEPI2C_AW-1:0] eepi2c_addr_t;
    typedef logic [`EEPI2C_DW-1:0] eepi2c_byte_t;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_DEVADR,
        ST_WADR_HI,
        ST_WADR_LO,
        ST_DATA,
        ST_DONE,
        ST_IGNORE
    } eepi2c_state_t;

    typedef struct packed
    {
        eepi2c_addr_t addr;
        eepi2c_byte_t data;
    } eepi2c_wr_t;

    function automatic logic eepi2c_dev_match(
        input eepi2c_byte_t b,
        input logic [3:0]   dtype,
        input logic         sel_hi,
        input logic         sel_lo
    );
        return (b[`EEPI2C_TYPE_HI:`EEPI2C_TYPE_LO] == dtype)
            && (b[`EEPI2C_SEL_HI] == sel_hi)
            && (b[`EEPI2C_SEL_LO] == sel_lo);
    endfunction : eepi2c_dev_match

endpackage : eepi2c_pkg

// >>> rtl/eepi2c_sync.sv
`timescale 1ns/10ps

module eepi2c_sync #(
    parameter int unsigned W = 1
) (
    // clock
    input  wire logic         clk,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // first stage is read only by the second stage
    logic [W-1:0] stage1_r;
    logic [W-1:0] q_r;

    always_ff @(posedge clk)
    begin
        stage1_r <= d;
        q_r      <= stage1_r;
    end

    assign q = q_r;

endmodule : eepi2c_sync

// >>> rtl/eepi2c_mem.sv
`timescale 1ns/10ps

module eepi2c_mem #(
    parameter int unsigned AW = 17,
    parameter int unsigned DW = 8
) (
    // clock
    input  wire logic          clk,
    // write port
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [DW-1:0] wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output logic      [DW-1:0] rdata
);

    logic [DW-1:0] mem [2**AW];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        rdata_r <= mem[raddr];
    end

    assign rdata = rdata_r;

endmodule : eepi2c_mem

// >>> rtl/eepi2c_slave.sv
`timescale 1ns/10ps
`include "eepi2c_defs.svh"

// Function
// - sample on rising clock, change driven bit after falling clock, MSB first
// - detect start and stop by data edges while clock high, always watching
// - after eighth bit sender releases; receiver holds data low through ninth clock
// - on master no-acknowledge while device sends, release data line for stop; this device never sends, reads go unanswered
// - acknowledging party releases data line when the ninth clock ends
// - standby after power-up, after non-programming stop, after programming ends
// - master clocks up to nine dummy clocks until data line released
// - array holds 512 pages of 256 bytes
// - address byte bits 7..4 carry the fixed device type identifier
// - address byte bits 3 and 2 must match the two select inputs
// - address byte bit 1 is word address top bit
// - address byte bit 0 high means read, low means write
// - acknowledge matching write address byte, never a mismatching one
// - two word address bytes follow the address byte, forming 17 bits
// - first word address byte carries address bits 15..8, acknowledged
// - second word address byte carries address bits 7..0, acknowledged
// - data byte acknowledged, following stop launches timed programming cycle
// - during programming ignore bus and give no response
// - withhold acknowledge of write address byte while programming
module eepi2c_slave #(
    parameter int unsigned PROG_CYCLES = `EEPI2C_PROG_CYCLES,
    parameter logic [3:0]  DEV_TYPE    = `EEPI2C_DEV_TYPE,
    parameter int unsigned PAGES       = `EEPI2C_PAGES,
    parameter int unsigned PAGE_BYTES  = `EEPI2C_PAGE_BYTES
) (
    // system clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // two-wire link
    input  wire logic                link_clk,
    input  wire logic                scl_i,
    input  wire logic                sda_i,
    output logic                     sda_o,
    output logic                     sda_oe,
    // hardware select straps
    input  wire logic                hw_select_hi,
    input  wire logic                hw_select_lo,
    // status
    output logic                     standby,
    output logic                     prog_busy,
    // array inspection
    input  wire eepi2c_pkg::eepi2c_addr_t rd_addr,
    output eepi2c_pkg::eepi2c_byte_t      rd_data
);
    import eepi2c_pkg::*;

    localparam int unsigned AW = $clog2(PAGES * PAGE_BYTES);
    localparam int unsigned CW = $clog2(PROG_CYCLES);

    // ----------------------------------------
    // link domain: synchronisers
    // ----------------------------------------
    logic          link_rst;
    logic [3:0]    pins_s;
    logic          scl_s;
    logic          sda_s;
    logic          sel_hi_s;
    logic          sel_lo_s;
    logic          ack_tgl_s;
    logic          scl_q_r;
    logic          sda_q_r;
    logic          ack_q_r;

    eepi2c_sync #(.W(1)) u_rst_sync (
        .clk (link_clk),
        .d   (sys_rst),
        .q   (link_rst)
    );

    eepi2c_sync #(.W(4)) u_pin_sync (
        .clk (link_clk),
        .d   ({scl_i, sda_i, hw_select_hi, hw_select_lo}),
        .q   (pins_s)
    );

    assign {scl_s, sda_s, sel_hi_s, sel_lo_s} = pins_s;

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end
        else
        begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // ----------------------------------------
    // link domain: bus events
    // ----------------------------------------
    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;
    logic          byte_end;
    logic          slot_end;
    logic          busy;
    logic          prog_done;
    logic          req_tgl_r;
    logic [3:0]    bit_cnt_r;
    logic          ack_slot_r;
    logic [7:0]    shift_r;
    eepi2c_state_t state_r;
    eepi2c_state_t pend_r;
    eepi2c_state_t after_nxt;
    logic          ack_ok;
    logic          dev_hit;

    assign scl_rise  = scl_s & ~scl_q_r;
    assign scl_fall  = ~scl_s & scl_q_r;
    assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;
    assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;
    assign byte_end  = scl_fall & (bit_cnt_r == `EEPI2C_CNT_ACK) & ~ack_slot_r;
    assign slot_end  = scl_fall & ack_slot_r;
    // a launched request counts as busy until the system side echoes it back
    assign busy      = req_tgl_r ^ ack_tgl_s;
    assign prog_done = ack_tgl_s ^ ack_q_r;
    assign dev_hit   = eepi2c_dev_match(shift_r, DEV_TYPE, sel_hi_s, sel_lo_s);

    // ----------------------------------------
    // link domain: acknowledge decision
    // ----------------------------------------
    always_comb
    begin
        ack_ok    = 1'b0;
        after_nxt = ST_IGNORE;
        unique case (state_r)
            ST_DEVADR:
            begin
                // reads are not served by this block, so they go unanswered
                ack_ok = dev_hit & ~shift_r[`EEPI2C_RW_BIT] & ~busy;
                after_nxt = ack_ok ? ST_WADR_HI : ST_IGNORE;
            end
            ST_WADR_HI:
            begin
                ack_ok    = 1'b1;
                after_nxt = ST_WADR_LO;
            end
            ST_WADR_LO:
            begin
                ack_ok    = 1'b1;
                after_nxt = ST_DATA;
            end
            ST_DATA:
            begin
                ack_ok    = 1'b1;
                after_nxt = ST_DONE;
            end
            ST_IDLE,
            ST_DONE,
            ST_IGNORE:
            begin
                ack_ok    = 1'b0;
                after_nxt = ST_IGNORE;
            end
        endcase
    end

    // ----------------------------------------
    // link domain: sequencer
    // ----------------------------------------
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            state_r    <= ST_IDLE;
            pend_r     <= ST_IDLE;
            bit_cnt_r  <= `EEPI2C_CNT_ZERO;
            ack_slot_r <= 1'b0;
        end
        else if (start_det)
        begin
            state_r    <= busy ? ST_IGNORE : ST_DEVADR;
            bit_cnt_r  <= `EEPI2C_CNT_ZERO;
            ack_slot_r <= 1'b0;
        end
        else if (stop_det)
        begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= `EEPI2C_CNT_ZERO;
            ack_slot_r <= 1'b0;
        end
        else if (state_r != ST_IDLE && state_r != ST_IGNORE)
        begin
            if (scl_rise && bit_cnt_r != `EEPI2C_CNT_ACK)
            begin
                bit_cnt_r <= bit_cnt_r + `EEPI2C_CNT_ONE;
            end
            if (byte_end)
            begin
                ack_slot_r <= 1'b1;
                pend_r     <= after_nxt;
            end
            if (slot_end)
            begin
                ack_slot_r <= 1'b0;
                bit_cnt_r  <= `EEPI2C_CNT_ZERO;
                state_r    <= pend_r;
            end
        end
    end

    // msb arrives first, sampled on the rising clock
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            shift_r <= 8'h00;
        end
        else if (scl_rise && !ack_slot_r && bit_cnt_r != `EEPI2C_CNT_ACK)
        begin
            shift_r <= {shift_r[6:0], sda_s};
        end
    end

    // ----------------------------------------
    // link domain: open-drain drive
    // ----------------------------------------
    logic sda_oe_r;

    always_ff @(posedge link_clk)
    begin
        if (link_rst || start_det || stop_det)
        begin
            sda_oe_r <= 1'b0;
        end
        else if (byte_end)
        begin
            sda_oe_r <= ack_ok;
        end
        else if (slot_end)
        begin
            sda_oe_r <= 1'b0;
        end
    end

    assign sda_o  = 1'b0;
    assign sda_oe = sda_oe_r;

    // ----------------------------------------
    // link domain: address and data capture
    // ----------------------------------------
    eepi2c_addr_t addr_r;
    eepi2c_byte_t data_r;

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            addr_r <= '0;
            data_r <= 8'h00;
        end
        else if (byte_end && ack_ok)
        begin
            unique case (state_r)
                ST_DEVADR:  addr_r[AW-1]   <= shift_r[`EEPI2C_TOP_BIT];
                ST_WADR_HI: addr_r[`EEPI2C_WHI_MSB:`EEPI2C_WHI_LSB] <= shift_r;
                ST_WADR_LO: addr_r[`EEPI2C_WLO_MSB:`EEPI2C_WLO_LSB] <= shift_r;
                ST_DATA:    data_r         <= shift_r;
                default:    data_r         <= data_r;
            endcase
        end
    end

    // ----------------------------------------
    // link domain: write launch and standby
    // ----------------------------------------
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            req_tgl_r <= 1'b0;
            ack_q_r   <= 1'b0;
        end
        else
        begin
            ack_q_r <= ack_tgl_s;
            if (stop_det && state_r == ST_DONE && !busy)
            begin
                req_tgl_r <= ~req_tgl_r;
            end
        end
    end

    logic standby_r;

    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            standby_r <= 1'b1;
        end
        else if (prog_done)
        begin
            standby_r <= 1'b1;
        end
        else if (stop_det && state_r != ST_DONE && !busy)
        begin
            standby_r <= 1'b1;
        end
        else if (start_det && !busy)
        begin
            standby_r <= 1'b0;
        end
    end

    assign standby = standby_r;

    // ----------------------------------------
    // system domain: programming cycle
    // ----------------------------------------
    logic          req_s;
    logic          req_q_r;
    logic          req_evt;
    logic          prog_busy_r;
    logic [CW-1:0] prog_cnt_r;
    logic          ack_tgl_r;
    eepi2c_wr_t    wr;

    eepi2c_sync #(.W(1)) u_req_sync (
        .clk (sys_clk),
        .d   (req_tgl_r),
        .q   (req_s)
    );

    eepi2c_sync #(.W(1)) u_ack_sync (
        .clk (link_clk),
        .d   (ack_tgl_r),
        .q   (ack_tgl_s)
    );

    // address and data stay frozen while the request is outstanding
    assign wr      = '{addr: addr_r, data: data_r};
    assign req_evt = req_s ^ req_q_r;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            req_q_r     <= 1'b0;
            prog_busy_r <= 1'b0;
            prog_cnt_r  <= '0;
            ack_tgl_r   <= 1'b0;
        end
        else
        begin
            req_q_r <= req_s;
            if (req_evt)
            begin
                prog_busy_r <= 1'b1;
                prog_cnt_r  <= '0;
            end
            else if (prog_busy_r)
            begin
                if (prog_cnt_r == CW'(PROG_CYCLES - 1))
                begin
                    prog_busy_r <= 1'b0;
                    ack_tgl_r   <= ~ack_tgl_r;
                end
                else
                begin
                    prog_cnt_r <= prog_cnt_r + 1'b1;
                end
            end
        end
    end

    assign prog_busy = prog_busy_r;

    eepi2c_mem #(.AW(AW), .DW(`EEPI2C_DW)) u_mem (
        .clk   (sys_clk),
        .we    (req_evt),
        .waddr (wr.addr),
        .wdata (wr.data),
        .raddr (rd_addr),
        .rdata (rd_data)
    );

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_oe_after_fall;
        @(posedge link_clk) disable iff (link_rst)
        $rose(sda_oe_r) |-> $past(scl_fall);
    endproperty
    a_oe_after_fall: assert property (p_oe_after_fall)
        else $error("data line driven without a falling clock");

    property p_start_enter;
        @(posedge link_clk) disable iff (link_rst)
        start_det && !busy |=> state_r == ST_DEVADR && bit_cnt_r == `EEPI2C_CNT_ZERO;
    endproperty
    a_start_enter: assert property (p_start_enter)
        else $error("start did not begin address byte");

    property p_oe_in_slot;
        @(posedge link_clk) disable iff (link_rst)
        sda_oe_r |-> ack_slot_r;
    endproperty
    a_oe_in_slot: assert property (p_oe_in_slot)
        else $error("data line driven outside acknowledge slot");

    property p_slot_release;
        @(posedge link_clk) disable iff (link_rst)
        slot_end && !start_det && !stop_det |=> !sda_oe_r && bit_cnt_r == `EEPI2C_CNT_ZERO;
    endproperty
    a_slot_release: assert property (p_slot_release)
        else $error("data line held after ninth clock");

    property p_standby_stop;
        @(posedge link_clk) disable iff (link_rst)
        stop_det && state_r != ST_DONE && !busy && !prog_done |=> standby_r;
    endproperty
    a_standby_stop: assert property (p_standby_stop)
        else $error("no standby after plain stop");

    property p_addr_ack;
        @(posedge link_clk) disable iff (link_rst)
        byte_end && state_r == ST_DEVADR && !start_det && !stop_det
        |=> sda_oe_r == (dev_hit && !shift_r[`EEPI2C_RW_BIT] && !busy) [*2];
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("wrong answer to address byte");

    property p_hi_capture;
        @(posedge link_clk) disable iff (link_rst)
        byte_end && state_r == ST_WADR_HI && !start_det && !stop_det
        |=> addr_r[`EEPI2C_WHI_MSB:`EEPI2C_WHI_LSB] == $past(shift_r);
    endproperty
    a_hi_capture: assert property (p_hi_capture)
        else $error("first word address byte not captured");

    property p_launch;
        @(posedge link_clk) disable iff (link_rst)
        stop_det && state_r == ST_DONE && !busy |=> busy && !standby_r;
    endproperty
    a_launch: assert property (p_launch)
        else $error("stop after data did not launch programming");

    property p_busy_quiet;
        @(posedge link_clk) disable iff (link_rst)
        busy && !$past(busy) |-> !sda_oe_r throughout (busy [*3]);
    endproperty
    a_busy_quiet: assert property (p_busy_quiet)
        else $error("response given while programming");

    property p_ignore_quiet;
        @(posedge link_clk) disable iff (link_rst)
        state_r == ST_IGNORE |-> !sda_oe_r;
    endproperty
    a_ignore_quiet: assert property (p_ignore_quiet)
        else $error("data line driven after refusal");

    property p_prog_end;
        @(posedge sys_clk) disable iff (sys_rst)
        prog_busy_r && !req_evt && prog_cnt_r == CW'(PROG_CYCLES - 1) |=> !prog_busy_r;
    endproperty
    a_prog_end: assert property (p_prog_end)
        else $error("programming cycle overran");

    property p_cov_ack;
        @(posedge link_clk) disable iff (link_rst)
        byte_end && state_r == ST_DEVADR && ack_ok;
    endproperty
    c_cov_ack: cover property (p_cov_ack);

    property p_cov_nack;
        @(posedge link_clk) disable iff (link_rst)
        byte_end && state_r == ST_DEVADR && !ack_ok;
    endproperty
    c_cov_nack: cover property (p_cov_nack);

    property p_cov_launch;
        @(posedge link_clk) disable iff (link_rst)
        stop_det && state_r == ST_DONE && !busy;
    endproperty
    c_cov_launch: cover property (p_cov_launch);

    property p_cov_done;
        @(posedge link_clk) disable iff (link_rst)
        prog_done;
    endproperty
    c_cov_done: cover property (p_cov_done);

endmodule : eepi2c_slave

// >>> testbench/eepi2c_mst.sv
`timescale 1ns/10ps

module eepi2c_mst (
    // link
    input  wire logic link_clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_m
);
    // ----
    // bus phases
    // ----
    // scl idles high outside frames and only moves inside the tasks
    initial
    begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end

    task automatic w(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask : w

    task automatic start;
        sda_m = 1'b1;
        w(3);
        scl = 1'b1;
        w(6);
        sda_m = 1'b0;
        w(6);
        scl = 1'b0;
        w(3);
    endtask : start

    task automatic stop;
        sda_m = 1'b0;
        w(3);
        scl = 1'b1;
        w(6);
        sda_m = 1'b1;
        w(6);
    endtask : stop

    // ----
    // byte with ninth clock
    // ----
    // eight data clocks only, the ninth is left to the caller
    task automatic bits8(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            sda_m = b[i];
            w(3);
            scl = 1'b1;
            w(6);
            scl = 1'b0;
            w(3);
        end
    endtask : bits8

    task automatic clk9(input logic [7:0] b, output logic ack);
        logic k;
        bits8(b);
        sda_m = 1'b1;
        w(3);
        scl = 1'b1;
        w(1);
        k = sda;
        w(4);
        // acknowledge must read low both early and late in the high phase
        ack = !k && !sda;
        scl = 1'b0;
        w(6);
    endtask : clk9

    task automatic dummy(output int n);
        n = 0;
        while (sda !== 1'b1 && n < 9)
        begin
            scl = 1'b1;
            w(6);
            scl = 1'b0;
            w(6);
            n++;
        end
    endtask : dummy
endmodule : eepi2c_mst

// >>> testbench/eepi2c_slave_tb_top.sv
`timescale 1ns/10ps
`include "eepi2c_defs.svh"

module eepi2c_slave_tb_top;
    import eepi2c_pkg::*;
    // ----
    // signals
    // ----
    localparam int P = 400;
    logic          sys_clk  = 1'b0;
    logic          link_clk = 1'b0;
    logic          sys_rst  = 1'b1;
    logic          sel_hi   = 1'b0;
    logic          sel_lo   = 1'b0;
    logic          scl;
    logic          sda_m;
    logic          sda_o;
    logic          sda_oe;
    logic          standby;
    logic          prog_busy;
    eepi2c_addr_t  rd_addr  = '0;
    eepi2c_byte_t  rd_data;
    logic [7:0]    mem [int];
    logic [15:0]   rnd      = 16'h77F6;
    int            err_total = 0;
    int            n_tests   = 0;
    int            busy_n;
    wire           sda = sda_m & (sda_oe ? sda_o : 1'b1);

    always #20 sys_clk = ~sys_clk;
    // 48 ns against 40 ns keeps the link edges sliding across the system edges
    always #24 link_clk = ~link_clk;
    always @(posedge sys_clk) if (prog_busy === 1'b1) busy_n++;

    eepi2c_slave #(.PROG_CYCLES(P)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .link_clk(link_clk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .hw_select_hi(sel_hi), .hw_select_lo(sel_lo), .standby(standby),
        .prog_busy(prog_busy), .rd_addr(rd_addr), .rd_data(rd_data));
    eepi2c_mst m (.link_clk(link_clk), .sda(sda), .scl(scl), .sda_m(sda_m));

    // ----
    // helpers
    // ----
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx

    function automatic logic [7:0] devb(input logic a16, input logic rw);
        return {`EEPI2C_DEV_TYPE, sel_hi, sel_lo, a16, rw};
    endfunction : devb

    task automatic chk(input logic [16:0] e, input logic [16:0] g);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task automatic xfer(input eepi2c_addr_t a, input eepi2c_byte_t d);
        logic k;
        m.start();
        m.clk9(devb(a[16], 1'b0), k);
        chk(1'b1, k);
        chk(1'b0, standby);
        m.clk9(a[15:8], k);
        chk(1'b1, k);
        m.clk9(a[7:0], k);
        chk(1'b1, k);
        m.clk9(d, k);
        chk(1'b1, k);
        chk(1'b0, sda_oe);
        mem[a] = d;
        busy_n = 0;
        m.stop();
    endtask : xfer

    task automatic rdchk(input eepi2c_addr_t a);
        @(posedge sys_clk);
        #1;
        rd_addr = a;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(mem[a], rd_data);
    endtask : rdchk

    // ----
    // scenarios
    // ----
    initial
    begin
        #3_000_000;
        err_total++;
        complete_run();
    end

    initial
    begin
        eepi2c_addr_t a;
        logic         k;
        int           n;
        logic [7:0]   bad [3];
        repeat (5) @(posedge sys_clk);
        #1;
        chk(1'b1, standby);
        chk(1'b0, prog_busy);
        chk(1'b0, sda_oe);
        sys_rst = 1'b0;
        m.w(10);
        for (int t = 0; t < 4; t++)
        begin
            rnd = nx(rnd);
            {sel_hi, sel_lo} = rnd[1:0];
            a[15:0] = rnd;
            rnd = nx(rnd);
            a[16] = rnd[3];
            m.w(8);
            if (t == 1)
            begin
                m.start();
                m.clk9(devb(1'b0, 1'b0), k);
                m.clk9(8'hFF, k);
            end
            xfer(a, rnd[15:8]);
            m.start();
            m.clk9(devb(1'b0, 1'b0), k);
            chk(1'b0, k);
            m.stop();
            n = 0;
            while (prog_busy !== 1'b0 && n < 5000)
            begin
                @(posedge sys_clk);
                n++;
            end
            m.w(8);
            chk(P, busy_n);
            chk(1'b1, standby);
            rdchk(a);
        end
        bad[0] = {4'h9, sel_hi, sel_lo, 2'b00};
        bad[1] = {`EEPI2C_DEV_TYPE, ~sel_hi, sel_lo, 2'b00};
        bad[2] = devb(1'b0, 1'b1);
        foreach (bad[i])
        begin
            m.start();
            m.clk9(bad[i], k);
            chk(1'b0, k);
            m.clk9(devb(1'b0, 1'b0), k);
            chk(1'b0, k);
            m.stop();
            m.w(8);
            chk(1'b0, prog_busy);
        end
        // cut the frame after eight clocks so the device is left holding its acknowledge
        m.start();
        m.clk9(devb(1'b0, 1'b0), k);
        m.bits8(8'h5B);
        m.w(6);
        chk(1'b0, sda);
        m.dummy(n);
        chk(1'b1, sda);
        chk(1'b1, n >= 1 && n <= 9);
        m.stop();
        m.w(8);
        chk(1'b1, standby);
        chk(1'b0, prog_busy);
        foreach (mem[i]) rdchk(i[16:0]);
        complete_run();
    end
endmodule : eepi2c_slave_tb_top
